/* File: acc_pkg.sv */
package acc_pkg;

  // ==========================================
  // register map (byte addresses)
  localparam logic [7:0] CSR_OFF = 8'h00;
  localparam logic [7:0] STS_OFF = 8'h04;
  localparam logic [7:0] IEN_OFF = 8'h08;
  localparam logic [7:0] ICLR_OFF = 8'h0C;

  // ==========================================
  // status and control field positions
  localparam int ENABLE_BIT = 7;
  localparam int REF_BIT = 6;
  localparam int FLAG_BIT = 5;
  localparam int IE_BIT = 4;
  localparam int ACO_BIT = 3;
  localparam int OPE_BIT = 2;
  localparam int MODE_LSB = 0;

  // ==========================================
  // interrupt status bit positions
  localparam int EVT_CMP = 0;
  localparam int EVT_RISE = 1;
  localparam int EVT_FALL = 2;
  localparam int EVT_W = 3;

  // ==========================================
  // reset values and counts
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [2:0] EVT_RESET = 3'h0;
  localparam logic [1:0] WARM_CYCLES = 2'h3;

  // ==========================================
  // edge-select codes and bus answers
  localparam logic [1:0] MODE_RISE = 2'h1;
  localparam logic [1:0] MODE_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    ACC_IDLE,
    ACC_BUSY
  } acc_phase_t;

  function automatic logic acc_edge_hit(input logic [1:0] mode, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    if (mode == MODE_BOTH) begin
      hit = rise | fall;
    end else if (mode == MODE_RISE) begin
      hit = rise;
    end else begin
      hit = fall;
    end
    return hit;
  endfunction

endpackage

/* File: acc_ctrl.sv */
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// How it works
// [RULE1] bit 7 enables the comparator; clear keeps it off
// [RULE2] bit 6 picks positive pin (0) or bandgap reference (1)
// [RULE3] selected output edge sets the event flag in bit 5
// [RULE4] writing one to bit 5 clears the flag; zero leaves it
// [RULE5] with bit 4 set, interrupt is high while the flag is set
// [RULE6] bit 3 reads the present comparator output, read-only
// [RULE7] output status bit resets to zero and reads zero while disabled
// [RULE8] bit 2 drives the comparator output onto the output pin
// [RULE9] bits 1:0: 00/10 falling, 01 rising, 11 either edge
// [RULE10] output is high when non-inverting input exceeds inverting input
// [RULE11] inverting input always comes from the negative-input pin
// [RULE12] all fields live in one 8-bit status and control register
// [RULE13] inactive in stop; deep stops return all state to reset (here sync_q[1:0] keep sampling comparator_raw)
// [RULE14] light stop keeps state; a reset exit returns to reset
// [RULE15] keeps comparing in wait mode so its interrupt can wake
// [RULE16] comparator output passes two flip-flops before any use
// [RULE17] reset clears every field and flag; disabled, no irq, no pin
module acc_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_raw,
  input wire logic stop_light,
  input wire logic stop_deep,
  output logic comparator_enable,
  output logic reference_select,
  output logic comparator_output_pin,
  output logic output_pin_drive_n,
  output logic irq
);
  import acc_pkg::*;

  if (ADDR_W < 4 || ADDR_W > 8) begin
    $error("ADDR_W must be 4 to 8");
  end

  // ==========================================
  // bus slave state
  acc_phase_t wr_phase_q, wr_phase_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] waddr_q, waddr_d, wbyte_q, wbyte_d;
  logic wstrb0_q, wstrb0_d;
  logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_wr;
  logic [7:0] raddr;

  // ==========================================
  // block state
  logic [7:0] csr_q, csr_d;
  logic [EVT_W-1:0] sts_q, sts_d, ien_q, ien_d;
  logic [2:0] sync_q, sync_d;
  logic [1:0] warm_q, warm_d;
  logic en_out_q, en_out_d, ref_q, ref_d, pin_q, pin_d, pin_n_q, pin_n_d;
  logic irq_q, irq_d;
  logic active, comparator_output_value, rise, fall, evt;

  // ==========================================
  // bus slave
  always_comb begin
    raddr = 8'h00;
    raddr[ADDR_W-1:0] = s_axi_araddr;
    do_wr = aw_have_q & w_have_q & (wr_phase_q == ACC_IDLE);
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    waddr_d = waddr_q;
    wbyte_d = wbyte_q;
    wstrb0_d = wstrb0_q;
    wr_phase_d = wr_phase_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      waddr_d = 8'h00;
      waddr_d[ADDR_W-1:0] = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wbyte_d = s_axi_wdata[7:0];
      wstrb0_d = s_axi_wstrb[0];
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      wr_phase_d = ACC_BUSY;
      bvalid_d = 1'b1;
      unique case (waddr_q)
        CSR_OFF, STS_OFF, IEN_OFF, ICLR_OFF: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
      wr_phase_d = ACC_IDLE;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      unique case (raddr)
        CSR_OFF: rdata_d[7:0] = {csr_q[7:4], comparator_output_value, csr_q[2:0]}; // [RULE6] [RULE12]
        STS_OFF: rdata_d[EVT_W-1:0] = sts_q;
        IEN_OFF: rdata_d[EVT_W-1:0] = ien_q;
        ICLR_OFF: rdata_d = 32'h0000_0000;
        default: rresp_d = RESP_SLVERR;
      endcase
    end
    awready_d = ~aw_have_d & (wr_phase_d == ACC_IDLE);
    wready_d = ~w_have_d & (wr_phase_d == ACC_IDLE);
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_phase_q <= ACC_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 8'h00;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_phase_q <= wr_phase_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      waddr_q <= waddr_d;
      wbyte_q <= wbyte_d;
      wstrb0_q <= wstrb0_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // comparator sampling and edge detect
  always_comb begin
    // comparing stops in light stop; wait mode is not gated
    active = csr_q[ENABLE_BIT] & ~stop_light & ~stop_deep; // [RULE15]
    sync_d[0] = comparator_raw; // [RULE16] [RULE10]
    sync_d[1] = sync_q[0]; // [RULE16]
    sync_d[2] = active & sync_q[1];
    warm_d = 2'h0;
    if (active) begin
      warm_d = (warm_q == WARM_CYCLES) ? warm_q : warm_q + 2'h1;
    end
    // bit 3 stays low until the chain holds post-enable samples
    comparator_output_value = active & warm_q[1] & sync_q[1]; // [RULE7] [RULE6]
    // edges only once the chain holds real samples
    rise = (warm_q == WARM_CYCLES) & active & sync_q[1] & ~sync_q[2];
    fall = (warm_q == WARM_CYCLES) & active & ~sync_q[1] & sync_q[2];
    evt = acc_edge_hit(csr_q[MODE_LSB +: 2], rise, fall); // [RULE9] [RULE3]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q <= 3'h0;
      warm_q <= 2'h0;
    end else begin
      sync_q <= sync_d;
      warm_q <= warm_d;
    end
  end

  // ==========================================
  // registers and outputs
  always_comb begin
    csr_d = csr_q;
    ien_d = ien_q;
    sts_d = sts_q;
    if (do_wr && wstrb0_q) begin
      unique case (waddr_q)
        CSR_OFF: begin
          csr_d[ENABLE_BIT] = wbyte_q[ENABLE_BIT]; // [RULE1]
          csr_d[REF_BIT] = wbyte_q[REF_BIT]; // [RULE2]
          csr_d[IE_BIT] = wbyte_q[IE_BIT];
          csr_d[OPE_BIT] = wbyte_q[OPE_BIT];
          csr_d[MODE_LSB +: 2] = wbyte_q[MODE_LSB +: 2];
          if (wbyte_q[FLAG_BIT]) begin
            csr_d[FLAG_BIT] = 1'b0; // [RULE4]
          end
        end
        IEN_OFF: ien_d = wbyte_q[EVT_W-1:0];
        ICLR_OFF: sts_d = sts_q & ~wbyte_q[EVT_W-1:0];
        default: ;
      endcase
    end
    csr_d[ACO_BIT] = 1'b0;
    // a new event beats a same-cycle clear
    if (evt) begin
      csr_d[FLAG_BIT] = 1'b1; // [RULE3]
    end
    sts_d = sts_d | {fall, rise, evt};
    if (stop_deep) begin
      csr_d = CSR_RESET; // [RULE13]
      sts_d = EVT_RESET;
      ien_d = EVT_RESET;
    end
    en_out_d = csr_d[ENABLE_BIT] & ~stop_light & ~stop_deep; // [RULE1] [RULE13] [RULE14]
    ref_d = csr_d[REF_BIT]; // [RULE2] [RULE11]
    pin_d = csr_d[OPE_BIT] & en_out_d & comparator_output_value; // [RULE8]
    pin_n_d = ~(csr_d[OPE_BIT] & csr_d[ENABLE_BIT]); // [RULE8]
    irq_d = (csr_d[FLAG_BIT] & csr_d[IE_BIT]) | (|(sts_d & ien_d)); // [RULE5]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_q <= CSR_RESET; // [RULE17] [RULE14]
      sts_q <= EVT_RESET;
      ien_q <= EVT_RESET;
      en_out_q <= 1'b0;
      ref_q <= 1'b0;
      pin_q <= 1'b0;
      pin_n_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      csr_q <= csr_d;
      sts_q <= sts_d;
      ien_q <= ien_d;
      en_out_q <= en_out_d;
      ref_q <= ref_d;
      pin_q <= pin_d;
      pin_n_q <= pin_n_d;
      irq_q <= irq_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign comparator_enable = en_out_q;
  assign reference_select = ref_q;
  assign comparator_output_pin = pin_q;
  assign output_pin_drive_n = pin_n_q;
  assign irq = irq_q;

  // ==========================================
  // checks
  enable_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
    !csr_q[ENABLE_BIT] |-> !comparator_enable)
    else $error("comparator enabled while bit clear");

  ref_follow_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
    reference_select == csr_q[REF_BIT])
    else $error("reference select differs from register");

  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
    evt && !stop_deep |=> csr_q[FLAG_BIT])
    else $error("edge event did not set flag");

  flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
    do_wr && wstrb0_q && waddr_q == CSR_OFF && wbyte_q[FLAG_BIT] && !evt |=> !csr_q[FLAG_BIT])
    else $error("write one did not clear flag");

  irq_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
    csr_q[FLAG_BIT] && csr_q[IE_BIT] |-> irq)
    else $error("enabled flag without interrupt");

  aco_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
    !csr_q[ENABLE_BIT] [*2] |-> !sync_q[2] && !comparator_output_value)
    else $error("output status not zero while disabled");

  pin_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
    !csr_q[OPE_BIT] |-> output_pin_drive_n && !comparator_output_pin)
    else $error("pin driven while output disabled");

  sync_delay_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE16]
    rise |-> $past(comparator_raw, 2) && !$past(comparator_raw, 3))
    else $error("rising edge without two-stage delay");

  deep_reset_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
    stop_deep |=> csr_q == CSR_RESET && !irq && !comparator_enable)
    else $error("deep stop did not restore reset state");

endmodule

/* File: acc_cmp_model.sv */
`timescale 1ns/10ps
module acc_cmp_model (
  input wire logic aclk,
  input wire logic comparator_enable,
  input wire logic reference_select,
  input wire logic [7:0] level_pos,
  input wire logic [7:0] level_neg,
  input wire logic [7:0] level_gap,
  output logic comparator_raw
);
  logic wander_q = 1'h0;
  // ==========================================
  // powered down: output wanders every cycle
  always @(posedge aclk) begin
    wander_q <= ~wander_q;
  end
  always_comb begin
    if (!comparator_enable) begin
      comparator_raw = wander_q;
    end else begin
      comparator_raw = (reference_select ? level_gap : level_pos) > level_neg;
    end
  end
endmodule

/* File: acc_ctrl_test.sv */
`timescale 1ns/10ps
module acc_ctrl_test;
  import acc_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, lp = 8'h00, ln = 8'h10, lg = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic stop_light = 1'h0, stop_deep = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, raw, cen, rsel, opin, odrv_n, irq;
  logic [1:0] bresp, rresp, br, rr;
  int miscompares = 0, tests_run = 0, cycles = 0;

  acc_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comparator_raw(raw),
    .stop_light(stop_light), .stop_deep(stop_deep), .comparator_enable(cen), .reference_select(rsel),
    .comparator_output_pin(opin), .output_pin_drive_n(odrv_n), .irq(irq));
  acc_cmp_model cmp (.aclk(aclk), .comparator_enable(cen), .reference_select(rsel), .level_pos(lp),
    .level_neg(ln), .level_gap(lg), .comparator_raw(raw));

  // ==========================================
  // clock, timeout, report
  initial begin
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task summarize;
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ==========================================
  // bus cycles and analog stimulus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (awvalid || wvalid);
    do @(negedge aclk); while (!bvalid);
    br = bresp;
    @(posedge aclk);
    bready <= 1'h0;
  endtask
  task automatic rdt(input logic [7:0] a);
    logic ta;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end while (!ta);
    do @(negedge aclk); while (!rvalid);
    rd = rdata;
    rr = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask
  // positive pin on one side of the negative pin, bandgap on the other
  task automatic lvl(input logic hi);
    logic [7:0] n, d;
    n = 8'($urandom_range(20, 200));
    d = 8'($urandom_range(1, 19));
    @(posedge aclk);
    ln <= n;
    lp <= hi ? n + d : n - d;
    lg <= hi ? n - d : n + d;
    repeat (6) @(posedge aclk);
  endtask
  function automatic logic [31:0] csr_exp(int m, logic r);
    return 32'h80 | 32'(m) | (r ? 32'h8 : 32'h0) | ((m == 3 || (m == 1) == r) ? 32'h20 : 32'h0);
  endfunction

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h74DF3E73));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rdt(CSR_OFF);
    chk("csr reset", 32'h0, rd);
    chk("pins reset", 32'h2, {cen, rsel, opin, odrv_n, irq});
    for (int m = 0; m < 4; m++) begin
      wr(CSR_OFF, 32'hA0 | m);
      lvl(1'h1);
      rdt(CSR_OFF);
      chk("csr rise", csr_exp(m, 1'h1), rd);
      wr(CSR_OFF, 32'h80 | m);
      rdt(CSR_OFF);
      chk("csr write zero", csr_exp(m, 1'h1), rd);
      wr(CSR_OFF, 32'hA0 | m);
      lvl(1'h0);
      rdt(CSR_OFF);
      chk("csr fall", csr_exp(m, 1'h0), rd);
    end
    wr(CSR_OFF, 32'hC3);
    rdt(CSR_OFF);
    chk("csr bandgap", 32'hEB, rd);
    chk("ref out", 32'h1, rsel);
    wr(CSR_OFF, 32'hB5);
    repeat (6) @(posedge aclk);
    chk("irq idle", 32'h10, {cen, rsel, opin, odrv_n, irq});
    lvl(1'h1);
    chk("irq set", 32'h15, {cen, rsel, opin, odrv_n, irq});
    wr(CSR_OFF, 32'h85);
    chk("irq masked", 32'h14, {cen, rsel, opin, odrv_n, irq});
    wr(CSR_OFF, 32'h81);
    chk("pin off", 32'h12, {cen, rsel, opin, odrv_n, irq});
    rdt(STS_OFF);
    chk("status", 32'h7, rd);
    wr(IEN_OFF, 32'h1);
    chk("irq status", 32'h1, irq);
    wr(ICLR_OFF, 32'h7);
    rdt(STS_OFF);
    chk("status clear", 32'h0, rd);
    chk("irq clear", 32'h0, irq);
    rdt(ICLR_OFF);
    chk("clear reads", 32'h0, rd);
    wr(8'h10, 32'hFF);
    chk("bresp unmapped", 32'(RESP_SLVERR), 32'(br));
    rdt(8'h10);
    chk("rresp unmapped", 32'(RESP_SLVERR), 32'(rr));
    chk("rdata unmapped", 32'h0, rd);
    wr(CSR_OFF, 32'hA1);
    @(posedge aclk);
    stop_light <= 1'h1;
    lvl(1'h0);
    lvl(1'h1);
    chk("light stop off", 32'h0, cen);
    stop_light <= 1'h0;
    repeat (8) @(posedge aclk);
    rdt(CSR_OFF);
    chk("light stop held", 32'h89, rd);
    wstrb <= 4'h0;
    wr(CSR_OFF, 32'h0);
    wstrb <= 4'hF;
    chk("bresp no lanes", 32'(RESP_OKAY), 32'(br));
    rdt(CSR_OFF);
    chk("csr no lanes", 32'h89, rd);
    stop_deep <= 1'h1;
    @(posedge aclk);
    stop_deep <= 1'h0;
    rdt(CSR_OFF);
    chk("deep stop", 32'h0, rd);
    rdt(IEN_OFF);
    chk("deep stop ien", 32'h0, rd);
    wr(CSR_OFF, 32'hB5);
    stop_light <= 1'h1;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    stop_light <= 1'h0;
    chk("reset pins", 32'h2, {cen, rsel, opin, odrv_n, irq});
    rdt(CSR_OFF);
    chk("light stop reset", 32'h0, rd);
    summarize();
  end
endmodule
